// ---- rlsm_link_monitor.sv ----
// Settings decode, reply delay, link timeout supervision and fault reaction of the serial port.
//
// Contract
// - The station address 1 to 247 identifies this drive, and only queries naming it are answered.
// - Silence longer than the timeout setting (0.01 to 100.00 s, 0.00 turns it off) raises link loss; the serial link error code shows only on a trip.
// - The reaction code picks trip, decel then trip, ignore, coast stop or decel stop on a timeout.
// - A reply starts only after the reply delay of 0 to 1000 ms following a received query.
// - With terminal function 049 the link loss indicator follows the pending link loss.
// - The protocol code selects slave RTU, peer communication or peer administrator mode.
// - Timeout supervision starts only after the first transmission since reset.
// - Every character has 8 data bits, least significant bit first, binary coded.
module rlsm_link_monitor #(
    parameter int unsigned CYC_PER_MS = rlsm_pkg::CYC_PER_MS
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [7:0] i_station_address_setting,
    input wire logic [2:0] i_link_fault_reaction_select,
    input wire logic [13:0] i_link_timeout_setting,
    input wire logic [9:0] i_reply_delay_setting,
    input wire logic [1:0] i_protocol_mode_select,
    input wire logic [7:0] i_output_terminal_function_select,
    input wire logic i_query_done,
    input wire logic [7:0] i_query_addr,
    input wire logic i_tx_done,
    input wire logic i_motor_stopped,
    input wire logic i_error_release,
    output logic o_query_accept,
    output logic o_reply_start,
    output logic [7:0] o_serial_link_error_code,
    output logic o_trip,
    output logic o_decel_stop,
    output logic o_coast_stop,
    output logic o_link_loss_indicator,
    output logic o_mode_rtu,
    output logic o_mode_peer,
    output logic o_mode_admin,
    output logic [3:0] o_char_data_bits,
    output logic o_lsb_first
);
    rlsm_tick_if tick_bus ();

    rlsm_tick_div #(
        .CYC_PER_MS(CYC_PER_MS),
        .MS_PER_UNIT(rlsm_pkg::MS_PER_TIMEOUT_UNIT)
    ) u_div (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .tick(tick_bus.src)
    );

    // Address decode of a finished query.
    logic addr_valid, addr_hit, addr_group, reply_wanted;
    assign addr_valid = (i_station_address_setting >= rlsm_pkg::STATION_ADDR_MIN) &&
                        (i_station_address_setting <= rlsm_pkg::STATION_ADDR_MAX);
    assign addr_hit = addr_valid && (i_query_addr == i_station_address_setting);
    assign addr_group = (i_query_addr == rlsm_pkg::ADDR_BROADCAST) ||
                        ((i_query_addr >= rlsm_pkg::ADDR_GROUP_FIRST) &&
                         (i_query_addr <= rlsm_pkg::ADDR_GROUP_LAST));
    assign reply_wanted = i_query_done && addr_hit;

    // Reply delay timer counted in millisecond ticks.
    logic delay_run_q, delay_run_d, reply_q, reply_d, accept_q, accept_d;
    logic [9:0] delay_cnt_q, delay_cnt_d;
    always_comb begin
        delay_run_d = delay_run_q;
        delay_cnt_d = delay_cnt_q;
        reply_d = 1'b0;
        accept_d = i_query_done && (addr_hit || addr_group && addr_valid);
        if (reply_wanted) begin
            delay_run_d = 1'b1;
            delay_cnt_d = '0;
        end else if (delay_run_q) begin
            if (delay_cnt_q >= i_reply_delay_setting) begin
                delay_run_d = 1'b0;
                reply_d = 1'b1;
            end else if (tick_bus.tick_ms) begin
                delay_cnt_d = delay_cnt_q + 1'b1;
            end
        end
    end

    // Link supervision counted in 10 ms units.
    logic armed_q, armed_d, loss_q, loss_d, timeout_hit;
    logic [14:0] idle_cnt_q, idle_cnt_d;
    assign timeout_hit = armed_q && (i_link_timeout_setting != '0) &&
                         ({1'b0, i_link_timeout_setting} < idle_cnt_q);
    always_comb begin
        armed_d = armed_q | i_tx_done;
        idle_cnt_d = idle_cnt_q;
        loss_d = loss_q;
        if (i_query_done || !armed_q) begin
            idle_cnt_d = '0;
        end else if (tick_bus.tick_unit && idle_cnt_q != '1) begin
            idle_cnt_d = idle_cnt_q + 1'b1;
        end
        if (i_query_done || i_error_release) begin
            loss_d = 1'b0;
        end
        if (timeout_hit && !i_query_done) begin
            loss_d = 1'b1;
        end
    end

    // Fault reaction state machine.
    rlsm_pkg::rlsm_state_t state_q, state_d;
    logic loss_rise;
    assign loss_rise = loss_d && !loss_q;
    always_comb begin
        state_d = state_q;
        case (state_q)
            rlsm_pkg::RLSM_IDLE: begin
                if (loss_rise) begin
                    case (i_link_fault_reaction_select)
                        rlsm_pkg::REACT_TRIP: state_d = rlsm_pkg::RLSM_TRIPPED;
                        rlsm_pkg::REACT_DECEL_TRIP: state_d = rlsm_pkg::RLSM_DECEL;
                        rlsm_pkg::REACT_COAST, rlsm_pkg::REACT_DECEL: begin
                            state_d = rlsm_pkg::RLSM_HELD;
                        end
                        default: state_d = rlsm_pkg::RLSM_IDLE;
                    endcase
                end
            end
            rlsm_pkg::RLSM_DECEL: begin
                if (i_error_release) begin
                    state_d = rlsm_pkg::RLSM_IDLE;
                end else if (i_motor_stopped) begin
                    state_d = rlsm_pkg::RLSM_TRIPPED;
                end
            end
            rlsm_pkg::RLSM_TRIPPED: begin
                if (i_error_release) begin
                    state_d = rlsm_pkg::RLSM_IDLE;
                end
            end
            rlsm_pkg::RLSM_HELD: begin
                if (i_error_release || !loss_d) begin
                    state_d = rlsm_pkg::RLSM_IDLE;
                end
            end
            default: state_d = rlsm_pkg::RLSM_IDLE;
        endcase
    end

    // Output values registered from the next state, the next loss flag and the mode setting.
    logic trip_d, decel_d, coast_d, ind_d, rtu_d, peer_d, admin_d;
    logic [2:0] held_react_q, held_react_d;
    always_comb begin
        held_react_d = (state_q == rlsm_pkg::RLSM_IDLE) ? i_link_fault_reaction_select
                                                          : held_react_q;
        trip_d = (state_d == rlsm_pkg::RLSM_TRIPPED);
        decel_d = (state_d == rlsm_pkg::RLSM_DECEL) ||
                  ((state_d == rlsm_pkg::RLSM_HELD) &&
                   (held_react_d == rlsm_pkg::REACT_DECEL));
        coast_d = (state_d == rlsm_pkg::RLSM_HELD) &&
                  (held_react_d == rlsm_pkg::REACT_COAST);
        ind_d = loss_d && (i_output_terminal_function_select ==
                           rlsm_pkg::TERM_FUNC_LINK_LOSS);
        rtu_d = (i_protocol_mode_select != rlsm_pkg::MODE_PEER) &&
                (i_protocol_mode_select != rlsm_pkg::MODE_ADMIN);
        peer_d = (i_protocol_mode_select == rlsm_pkg::MODE_PEER);
        admin_d = (i_protocol_mode_select == rlsm_pkg::MODE_ADMIN);
    end

    // Register all state and outputs.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            delay_run_q <= 1'b0;
            delay_cnt_q <= '0;
            reply_q <= 1'b0;
            accept_q <= 1'b0;
            armed_q <= 1'b0;
            idle_cnt_q <= '0;
            loss_q <= 1'b0;
            state_q <= rlsm_pkg::RLSM_IDLE;
            held_react_q <= rlsm_pkg::REACT_TRIP;
            o_serial_link_error_code <= rlsm_pkg::NO_ERROR_CODE;
            o_trip <= 1'b0;
            o_decel_stop <= 1'b0;
            o_coast_stop <= 1'b0;
            o_link_loss_indicator <= 1'b0;
            o_mode_rtu <= 1'b1;
            o_mode_peer <= 1'b0;
            o_mode_admin <= 1'b0;
            o_char_data_bits <= rlsm_pkg::CHAR_DATA_BITS;
            o_lsb_first <= 1'b1;
        end else begin
            delay_run_q <= delay_run_d;
            delay_cnt_q <= delay_cnt_d;
            reply_q <= reply_d;
            accept_q <= accept_d;
            armed_q <= armed_d;
            idle_cnt_q <= idle_cnt_d;
            loss_q <= loss_d;
            state_q <= state_d;
            held_react_q <= held_react_d;
            o_serial_link_error_code <= trip_d ? rlsm_pkg::SERIAL_LINK_ERROR_CODE
                                               : rlsm_pkg::NO_ERROR_CODE;
            o_trip <= trip_d;
            o_decel_stop <= decel_d;
            o_coast_stop <= coast_d;
            o_link_loss_indicator <= ind_d;
            o_mode_rtu <= rtu_d;
            o_mode_peer <= peer_d;
            o_mode_admin <= admin_d;
            o_char_data_bits <= rlsm_pkg::CHAR_DATA_BITS;
            o_lsb_first <= 1'b1;
        end
    end

    assign o_query_accept = accept_q;
    assign o_reply_start = reply_q;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    a_foreign_addr_silent: assert property (i_query_done && !addr_hit && !delay_run_q
        |=> !delay_run_q [*2]) else $error("reply armed for a foreign address");
    a_zero_delay_reply: assert property (reply_wanted && i_reply_delay_setting == '0
        ##1 !i_query_done && i_reply_delay_setting == '0 |=> o_reply_start)
        else $error("zero reply delay did not reply");
    a_reply_waits_delay: assert property ($rose(o_reply_start)
        |-> $past(delay_run_q) && $past(delay_cnt_q) >= $past(i_reply_delay_setting))
        else $error("reply began before its delay");
    a_no_loss_unarmed: assert property (!armed_q |-> !loss_q)
        else $error("link loss before first transmission");
    a_timeout_sets_loss: assert property (timeout_hit && !i_query_done |=> loss_q)
        else $error("timeout did not raise link loss");
    a_query_clears_loss: assert property (i_query_done |=> !loss_q && idle_cnt_q == '0)
        else $error("query did not restart supervision");
    a_trip_shows_code: assert property (o_trip
        |-> o_serial_link_error_code == rlsm_pkg::SERIAL_LINK_ERROR_CODE)
        else $error("trip without the serial link error code");
    a_ignore_no_stop: assert property (state_q == rlsm_pkg::RLSM_IDLE && loss_rise &&
        i_link_fault_reaction_select == rlsm_pkg::REACT_IGNORE
        |=> ##1 !o_trip && !o_decel_stop && !o_coast_stop)
        else $error("ignore reaction stopped the drive");
    a_trip_reaction: assert property (state_q == rlsm_pkg::RLSM_IDLE && loss_rise &&
        i_link_fault_reaction_select == rlsm_pkg::REACT_TRIP |=> o_trip)
        else $error("trip reaction did not trip");
    a_indicator_follows: assert property (
        i_output_terminal_function_select == rlsm_pkg::TERM_FUNC_LINK_LOSS
        |=> o_link_loss_indicator == loss_q) else $error("indicator not following loss");
    a_mode_onehot: assert property ($onehot({o_mode_rtu, o_mode_peer, o_mode_admin}))
        else $error("protocol mode outputs not one-hot");
    a_char_format: assert property (o_char_data_bits == rlsm_pkg::CHAR_DATA_BITS && o_lsb_first)
        else $error("character format changed");

    c_reply_sent: cover property (reply_wanted ##[1:1000] o_reply_start);
    c_timeout_trip: cover property ($rose(loss_q) ##1 o_trip);
    c_decel_then_trip: cover property (o_decel_stop ##[1:20] o_trip);
    c_loss_cleared: cover property ($fell(loss_q));
endmodule // rlsm_link_monitor

// ---- rlsm_pkg.sv ----
// Package with the constants, codes and state type of the link settings monitor.
package rlsm_pkg;
    // Clock and time bases.
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned MS_PS = 1000000000;
    localparam int unsigned CYC_PER_MS = MS_PS / CLK_PERIOD_PS;
    localparam int unsigned MS_PER_TIMEOUT_UNIT = 10;
    // Setting ranges.
    localparam logic [7:0] STATION_ADDR_MIN = 8'h01;
    localparam logic [7:0] STATION_ADDR_MAX = 8'hf7;
    localparam logic [13:0] LINK_TIMEOUT_MAX = 14'h2710;
    localparam logic [9:0] REPLY_DELAY_MAX = 10'h3e8;
    // Broadcast addresses.
    localparam logic [7:0] ADDR_BROADCAST = 8'h00;
    localparam logic [7:0] ADDR_GROUP_FIRST = 8'hfa;
    localparam logic [7:0] ADDR_GROUP_LAST = 8'hfe;
    // Link-fault reaction codes.
    localparam logic [2:0] REACT_TRIP = 3'h0;
    localparam logic [2:0] REACT_DECEL_TRIP = 3'h1;
    localparam logic [2:0] REACT_IGNORE = 3'h2;
    localparam logic [2:0] REACT_COAST = 3'h3;
    localparam logic [2:0] REACT_DECEL = 3'h4;
    // Protocol mode codes.
    localparam logic [1:0] MODE_RTU = 2'h0;
    localparam logic [1:0] MODE_PEER = 2'h1;
    localparam logic [1:0] MODE_ADMIN = 2'h2;
    // Output terminal function for the link loss indicator.
    localparam logic [7:0] TERM_FUNC_LINK_LOSS = 8'h31;
    // Serial link error code shown on a trip.
    localparam logic [7:0] SERIAL_LINK_ERROR_CODE = 8'h29;
    localparam logic [7:0] NO_ERROR_CODE = 8'h00;
    // Character format.
    localparam logic [3:0] CHAR_DATA_BITS = 4'h8;
    // Fault reaction states, Gray coded along idle, decel, tripped.
    typedef enum logic [1:0] {
        RLSM_IDLE = 2'b00,
        RLSM_DECEL = 2'b01,
        RLSM_TRIPPED = 2'b11,
        RLSM_HELD = 2'b10
    } rlsm_state_t;
endpackage

// ---- rlsm_tick_if.sv ----
// Interface that carries the millisecond and timeout-unit ticks.
interface rlsm_tick_if;
    logic tick_ms;
    logic tick_unit;
    modport src (output tick_ms, output tick_unit);
    modport dst (input tick_ms, input tick_unit);
endinterface

// ---- rlsm_tick_div.sv ----
// Prescaler that makes the millisecond and timeout-unit enable pulses.
module rlsm_tick_div #(
    parameter int unsigned CYC_PER_MS = rlsm_pkg::CYC_PER_MS,
    parameter int unsigned MS_PER_UNIT = rlsm_pkg::MS_PER_TIMEOUT_UNIT
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    rlsm_tick_if.src tick
);
    localparam int CW = $clog2(CYC_PER_MS + 1);
    localparam int UW = $clog2(MS_PER_UNIT + 1);
    localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_MS - 1);
    localparam logic [UW-1:0] UNIT_LAST = UW'(MS_PER_UNIT - 1);

    logic [CW-1:0] cyc_q, cyc_d;
    logic [UW-1:0] ms_q, ms_d;
    logic tick_ms_q, tick_ms_d, tick_unit_q, tick_unit_d;

    // Count clocks to one millisecond, then milliseconds to one unit.
    always_comb begin
        cyc_d = cyc_q + 1'b1;
        ms_d = ms_q;
        tick_ms_d = 1'b0;
        tick_unit_d = 1'b0;
        if (cyc_q == CYC_LAST) begin
            cyc_d = '0;
            tick_ms_d = 1'b1;
            ms_d = ms_q + 1'b1;
            if (ms_q == UNIT_LAST) begin
                ms_d = '0;
                tick_unit_d = 1'b1;
            end
        end
    end

    // Register the prescaler state.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cyc_q <= '0;
            ms_q <= '0;
            tick_ms_q <= 1'b0;
            tick_unit_q <= 1'b0;
        end else begin
            cyc_q <= cyc_d;
            ms_q <= ms_d;
            tick_ms_q <= tick_ms_d;
            tick_unit_q <= tick_unit_d;
        end
    end

    assign tick.tick_ms = tick_ms_q;
    assign tick.tick_unit = tick_unit_q;
endmodule // rlsm_tick_div

// ---- rlsm_host_model.sv ----
// Host controller model that sends queries and reports the end of each reply.
module rlsm_host_model #(
    parameter int GAP_CYC = 2,
    parameter int TX_CYC = 6
) (
    input wire logic i_clk_sys,
    input wire logic i_reply_start,
    output logic o_query_done,
    output logic o_query_addr_valid,
    output logic [7:0] o_query_addr,
    output logic o_tx_done
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle link state at time zero.
    initial begin
        o_query_done = 1'b0;
        o_query_addr_valid = 1'b0;
        o_query_addr = 8'h5a;
        o_tx_done = 1'b0;
    end

    // Sends one query after the idle gap; the address is inverted once the strobe drops.
    task automatic send_query(input logic [7:0] addr);
        repeat (GAP_CYC) @(posedge i_clk_sys);
        #1;
        o_query_done = 1'b1;
        o_query_addr_valid = 1'b1;
        o_query_addr = addr;
        @(posedge i_clk_sys);
        #1;
        o_query_done = 1'b0;
        o_query_addr_valid = 1'b0;
        o_query_addr = ~addr;
    endtask

    // Reports a finished reply a fixed number of cycles after the reply starts.
    always @(posedge i_clk_sys) begin
        if (i_reply_start === 1'b1) begin
            repeat (TX_CYC) @(posedge i_clk_sys);
            #1;
            o_tx_done = 1'b1;
            @(posedge i_clk_sys);
            #1;
            o_tx_done = 1'b0;
        end
    end
endmodule // rlsm_host_model

// ---- rs485_link_settings_monitor_tb.sv ----
// Self-checking testbench of the serial link settings monitor.
module rs485_link_settings_monitor_tb;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        logic [7:0] station;
        logic [7:0] addr;
        logic [1:0] mode;
        logic acc;
        logic rep;
        logic [2:0] onehot;
    } rlsm_row_t;

    logic i_clk_sys = 1'b0;
    logic i_nrst;
    logic [7:0] i_station_address_setting;
    logic [2:0] i_link_fault_reaction_select;
    logic [13:0] i_link_timeout_setting;
    logic [9:0] i_reply_delay_setting;
    logic [1:0] i_protocol_mode_select;
    logic [7:0] i_output_terminal_function_select;
    logic i_motor_stopped;
    logic i_error_release;
    logic q_done, q_valid, tx_done, acc, rep, trip, decel, coast, ind, rtu, peer, admin, lsb;
    logic [7:0] q_addr, err_code;
    logic [3:0] dbits;
    int n_errors = 0;
    int num_checks = 0;
    int cnt, first;
    rlsm_row_t rows [7] = '{
        '{8'h05, 8'h05, 2'h0, 1'b1, 1'b1, 3'h4}, '{8'h05, 8'h06, 2'h1, 1'b0, 1'b0, 3'h2},
        '{8'h05, 8'h00, 2'h2, 1'b1, 1'b0, 3'h1}, '{8'hf7, 8'hfa, 2'h3, 1'b1, 1'b0, 3'h4},
        '{8'hf7, 8'hf7, 2'h0, 1'b1, 1'b1, 3'h4}, '{8'h00, 8'h00, 2'h0, 1'b0, 1'b0, 3'h4},
        '{8'hf8, 8'hf8, 2'h1, 1'b0, 1'b0, 3'h2}};

    // The clock toggles every half period of 2.5 ns.
    always #2.5 i_clk_sys = ~i_clk_sys;

    rlsm_link_monitor #(.CYC_PER_MS(4)) rlsm_link_monitor_i (.i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst), .i_station_address_setting(i_station_address_setting),
        .i_link_fault_reaction_select(i_link_fault_reaction_select),
        .i_link_timeout_setting(i_link_timeout_setting),
        .i_reply_delay_setting(i_reply_delay_setting),
        .i_protocol_mode_select(i_protocol_mode_select),
        .i_output_terminal_function_select(i_output_terminal_function_select),
        .i_query_done(q_done), .i_query_addr(q_addr), .i_tx_done(tx_done),
        .i_motor_stopped(i_motor_stopped), .i_error_release(i_error_release),
        .o_query_accept(acc), .o_reply_start(rep), .o_serial_link_error_code(err_code),
        .o_trip(trip), .o_decel_stop(decel), .o_coast_stop(coast),
        .o_link_loss_indicator(ind), .o_mode_rtu(rtu), .o_mode_peer(peer),
        .o_mode_admin(admin), .o_char_data_bits(dbits), .o_lsb_first(lsb));

    rlsm_host_model rlsm_host_model_i (.i_clk_sys(i_clk_sys), .i_reply_start(rep),
        .o_query_done(q_done), .o_query_addr_valid(q_valid), .o_query_addr(q_addr),
        .o_tx_done(tx_done));

    // Prints the verdict and ends the run.
    task automatic print_verdict();
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Compares one bit.
    task automatic chk_bit(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    // Compares one byte.
    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Checks that no loss or trip shows for n cycles.
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge i_clk_sys);
            #1;
            chk_bit("quiet", 1'b0, ind | trip);
        end
    endtask

    // Waits for loss or trip and checks that it did not come before lo cycles.
    task automatic wait_loss(input int lo);
        int k;
        k = 0;
        while ((ind | trip) !== 1'b1) begin
            @(posedge i_clk_sys);
            #1;
            k++;
            if (k > 200) begin
                n_errors++;
                print_verdict();
            end
        end
        chk_bit("loss_time", 1'b1, k >= lo);
    endtask

    // Main sequence: reset, table of address and mode cases, then delay and supervision.
    initial begin
        i_nrst = 1'b0;
        i_station_address_setting = 8'h05;
        i_link_fault_reaction_select = 3'h0;
        i_link_timeout_setting = 14'h0001;
        i_reply_delay_setting = 10'h000;
        i_protocol_mode_select = 2'h0;
        i_output_terminal_function_select = 8'h31;
        i_motor_stopped = 1'b0;
        i_error_release = 1'b0;
        repeat (4) @(posedge i_clk_sys);
        #1;
        chk_bit("rst_rtu", 1'b1, rtu);
        chk_byte("rst_bits", {4'h0, rlsm_pkg::CHAR_DATA_BITS}, {4'h0, dbits});
        chk_bit("rst_lsb", 1'b1, lsb);
        chk_bit("rst_trip", 1'b0, trip);
        i_nrst = 1'b1;
        quiet(150);
        i_link_timeout_setting = 14'h0000;
        foreach (rows[r]) begin
            i_station_address_setting = rows[r].station;
            i_protocol_mode_select = rows[r].mode;
            rlsm_host_model_i.send_query(rows[r].addr);
            chk_bit("accept", rows[r].acc, acc);
            chk_byte("mode", {5'h00, rows[r].onehot}, {5'h00, rtu, peer, admin});
            @(posedge i_clk_sys);
            #1;
            chk_bit("reply", rows[r].rep, rep);
        end
        // A second query during the delay restarts it and only one reply follows.
        i_station_address_setting = 8'h05;
        i_reply_delay_setting = 10'h002;
        rlsm_host_model_i.send_query(8'h05);
        rlsm_host_model_i.send_query(8'h05);
        cnt = 0;
        first = 0;
        for (int k = 1; k <= 30; k++) begin
            @(posedge i_clk_sys);
            #1;
            if (rep === 1'b1) begin
                cnt++;
                if (first == 0) first = k;
            end
        end
        chk_byte("reply_count", 8'h01, 8'(cnt));
        chk_bit("reply_delay", 1'b1, first >= 6 && first <= 11);
        i_reply_delay_setting = 10'h000;
        i_link_timeout_setting = 14'h0001;
        for (int c = 0; c <= 4; c++) begin
            i_link_fault_reaction_select = 3'(c);
            rlsm_host_model_i.send_query(8'h05);
            wait_loss(38);
            chk_bit("indicator", 1'b1, ind);
            chk_bit("trip", c == 0, trip);
            chk_bit("decel", c == 1 || c == 4, decel);
            chk_bit("coast", c == 3, coast);
            chk_byte("err_code", (c == 0) ? 8'h29 : 8'h00, err_code);
            if (c == 1) begin
                i_motor_stopped = 1'b1;
                repeat (4) @(posedge i_clk_sys);
                #1;
                chk_bit("trip_after_stop", 1'b1, trip);
                i_motor_stopped = 1'b0;
            end
            @(posedge i_clk_sys);
            #1;
            i_error_release = 1'b1;
            @(posedge i_clk_sys);
            #1;
            i_error_release = 1'b0;
            rlsm_host_model_i.send_query(8'h05);
            @(posedge i_clk_sys);
            #1;
            chk_bit("ind_clear", 1'b0, ind);
            chk_byte("clear", 8'h00, {trip, decel, coast, err_code[4:0]});
        end
        // A zero timeout switches supervision off.
        i_link_timeout_setting = 14'h0000;
        rlsm_host_model_i.send_query(8'h05);
        quiet(150);
        // Another terminal function keeps the indicator low during a trip.
        // The timeout is set only after the query has restarted the idle count.
        i_output_terminal_function_select = 8'h30;
        i_link_fault_reaction_select = 3'h0;
        rlsm_host_model_i.send_query(8'h05);
        i_link_timeout_setting = 14'h0001;
        wait_loss(38);
        chk_bit("ind_other_func", 1'b0, ind);
        chk_byte("err_other_func", 8'h29, err_code);
        print_verdict();
    end
endmodule // rs485_link_settings_monitor_tb
